// file: pkg/spec_ctl_pkg.sv
// Summary of operation
// - Move paired after an ALU op gets the ALU result directly, same cycle.
// - Result forwarding only for moves; move target may be register or memory.
// - Second reading data the first just wrote gets retained data, no read.
// - Bypass only for cacheable locations; otherwise the normal memory read.
// - With bypass the second pipe stalls for one clock only.
// - 512-entry 4-way target buffer plus separate 1024-entry history table.
// - Unconditional branch hitting the target buffer fetches from stored target.
// - Conditional hit follows prediction; conditional miss predicts not taken.
// - Taken choice comes from a four-state predictor using kept history.
// - Conditional branches issue to the primary pipe only.
// - Resolve in execute if flags ready earlier, writeback if set in parallel.
// - Correctly predicted branch completes in one clock, no penalty.
// - Mispredict flushes, refetches; penalty four (execute) or five (writeback).
// - Both predicted and alternate path are prefetched for conditionals that hit the target buffer.
// - Eight-entry return stack: call pushes return address, return pops it.
// - Conditional branch or float op checkpoints state and raises level, at most four.
// - Resolution lowers level; correct clears, mispredict restores in one clock.
// - Speculative writes held from cache and memory until branch resolved.
// - Speculation halts at level four, on faults, full buffers, unsaved state.
// - Pool of 32 physical registers; each register write gets a fresh one.
package spec_ctl_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int TGT_ENTRIES = 512;
    localparam int TGT_WAYS = 4;
    localparam int BHT_ENTRIES = 1024;
    localparam int RAS_DEPTH = 8;
    localparam int SPEC_MAX = 4;
    localparam int PHYS_REGS = 32;
    localparam int LOG_REGS = 8;
    // Misprediction penalties in core clocks
    localparam int PEN_EXECUTE = 4;
    localparam int PEN_WRITEBACK = 5;
    // Predictor counter reset value: weakly not taken
    localparam logic [1:0] CTR_RESET = 2'h1;
    localparam logic [1:0] CTR_MAX = 2'h3;
    localparam logic [1:0] CTR_MIN = 2'h0;
    // Bit position of the word index within a fetch address
    localparam int PC_LSB = 2;
endpackage
`default_nettype wire

// file: logic/return_stack.sv
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
    parameter int DEPTH = spec_ctl_pkg::RAS_DEPTH,
    parameter int W = spec_ctl_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Call and return
    input wire logic push,
    input wire logic [W-1:0] push_addr,
    input wire logic pop,
    // Top of stack
    output logic [W-1:0] top_addr,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] stack_q [DEPTH];
    logic [PW-1:0] ptr_q;
    logic [PW:0] count_q;

    // Stack storage; oldest entry is overwritten when full
    always_ff @(posedge clk)
    begin
        if (push)
            stack_q[ptr_q] <= push_addr;
    end

    // Pointer and fill count
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ptr_q <= '0;
            count_q <= '0;
        end
        else if (push && !pop)
        begin
            ptr_q <= ptr_q + 1'b1;
            if (count_q != (PW+1)'(DEPTH))
                count_q <= count_q + 1'b1;
        end
        else if (pop && !push && count_q != '0)
        begin
            ptr_q <= ptr_q - 1'b1;
            count_q <= count_q - 1'b1;
        end
    end

    assign top_addr = stack_q[ptr_q - 1'b1];
    assign empty = (count_q == '0);
endmodule // return_stack
`default_nettype wire

// file: logic/branch_speculation_forwarding.sv
`timescale 1ns/1ps
`default_nettype none
module branch_speculation_forwarding #(
    parameter int AW = spec_ctl_pkg::ADDR_W,
    parameter int DW = spec_ctl_pkg::DATA_W,
    parameter int TGT_N = spec_ctl_pkg::TGT_ENTRIES,
    parameter int WAYS = spec_ctl_pkg::TGT_WAYS,
    parameter int BHT_N = spec_ctl_pkg::BHT_ENTRIES,
    parameter int NPHYS = spec_ctl_pkg::PHYS_REGS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Paired result forwarding
    input wire logic x_res_valid,
    input wire logic [DW-1:0] x_res_data,
    input wire logic [2:0] x_res_lreg,
    input wire logic y_valid,
    input wire logic y_is_move,
    input wire logic [2:0] y_src_lreg,
    input wire logic [DW-1:0] y_reg_data,
    input wire logic y_dest_mem,
    output logic y_move_data_valid_q,
    output logic [DW-1:0] y_move_data_q,
    output logic y_move_to_mem_q,
    output logic fwd_used_q,
    // Memory data bypass
    input wire logic x_mem_wr,
    input wire logic [AW-1:0] x_mem_addr,
    input wire logic [DW-1:0] x_mem_wdata,
    input wire logic y_mem_rd,
    input wire logic [AW-1:0] y_mem_addr,
    input wire logic y_cacheable,
    output logic byp_used_q,
    output logic [DW-1:0] byp_data_q,
    output logic y_mem_read_q,
    output logic y_stall_q,
    // Fetch prediction
    input wire logic fetch_valid,
    input wire logic [AW-1:0] fetch_pc,
    input wire logic [AW-1:0] fetch_next_pc,
    input wire logic fetch_is_branch,
    input wire logic fetch_is_cond,
    input wire logic fetch_is_call,
    input wire logic fetch_is_ret,
    output logic redirect_q,
    output logic [AW-1:0] redirect_pc_q,
    output logic pred_taken_q,
    output logic alt_valid_q,
    output logic [AW-1:0] alt_pc_q,
    // Decode and issue
    input wire logic dec_valid,
    input wire logic dec_is_cond,
    input wire logic dec_is_fpu,
    output logic issue_x_only_q,
    output logic spec_accept_q,
    // Branch resolution
    input wire logic res_valid,
    input wire logic [AW-1:0] res_pc,
    input wire logic res_taken,
    input wire logic res_pred_taken,
    input wire logic [AW-1:0] res_target,
    input wire logic [AW-1:0] res_next_pc,
    input wire logic res_cc_parallel,
    input wire logic fpu_done,
    output logic res_late_q,
    output logic branch_done_q,
    output logic flush_q,
    output logic fetch_hold_q,
    // Speculation control
    input wire logic fault,
    input wire logic wbuf_full,
    input wire logic noncp_write,
    output logic [2:0] spec_level_q,
    output logic spec_halt_q,
    output logic ckpt_save_q,
    output logic ckpt_restore_q,
    output logic ckpt_clear_q,
    output logic mem_commit_en_q,
    output logic spec_write_discard_q,
    // Physical register pool
    input wire logic alloc_req,
    input wire logic [2:0] alloc_lreg,
    input wire logic free_req,
    input wire logic [4:0] free_phys,
    input wire logic [2:0] rd_lreg,
    output logic alloc_ok_q,
    output logic [4:0] alloc_phys_q,
    output logic [4:0] rd_phys_q
);
    localparam int SETS = TGT_N / WAYS;
    localparam int SW = $clog2(SETS);
    localparam int WW = $clog2(WAYS);
    localparam int TW = AW - SW - spec_ctl_pkg::PC_LSB;
    localparam int HW = $clog2(BHT_N);
    localparam int LW = $clog2(spec_ctl_pkg::SPEC_MAX);
    localparam int NL = spec_ctl_pkg::LOG_REGS;
    localparam logic [2:0] LVL_MAX = 3'(spec_ctl_pkg::SPEC_MAX);
    localparam logic [2:0] PEN_E = 3'(spec_ctl_pkg::PEN_EXECUTE);
    localparam logic [2:0] PEN_W = 3'(spec_ctl_pkg::PEN_WRITEBACK);

    // Target buffer and history storage
    logic bt_v_q [TGT_N];
    logic [TW-1:0] bt_tag_q [TGT_N];
    logic [AW-1:0] bt_pc_q [TGT_N];
    logic [1:0] bht_q [BHT_N];
    logic [WW-1:0] victim_q;

    function automatic logic [SW-1:0] set_of(input logic [AW-1:0] pc);
        set_of = pc[spec_ctl_pkg::PC_LSB +: SW];
    endfunction

    function automatic logic [TW-1:0] tag_of(input logic [AW-1:0] pc);
        tag_of = pc[AW-1 -: TW];
    endfunction

    function automatic logic [HW-1:0] hidx(input logic [AW-1:0] pc);
        hidx = pc[spec_ctl_pkg::PC_LSB +: HW];
    endfunction

    // Way hits
    logic [WAYS-1:0] f_hit, r_hit;
    generate
        for (genvar w = 0; w < WAYS; w++)
        begin : g_way
            localparam logic [WW-1:0] WI = WW'(w);
            assign f_hit[w] = bt_v_q[{set_of(fetch_pc), WI}]
                && bt_tag_q[{set_of(fetch_pc), WI}] == tag_of(fetch_pc);
            assign r_hit[w] = bt_v_q[{set_of(res_pc), WI}]
                && bt_tag_q[{set_of(res_pc), WI}] == tag_of(res_pc);
        end
    endgenerate

    function automatic logic [WW-1:0] way_of(input logic [WAYS-1:0] h);
        way_of = '0;
        for (int i = 0; i < WAYS; i++)
            if (h[i])
                way_of = WW'(i);
    endfunction

    logic [AW-1:0] f_tgt;
    logic ras_empty;
    logic [AW-1:0] ras_top;
    logic f_taken;
    assign f_tgt = bt_pc_q[{set_of(fetch_pc), way_of(f_hit)}];
    // Taken if upper half
    assign f_taken = bht_q[hidx(fetch_pc)][1];

    // Return address stack
    return_stack #(.DEPTH(spec_ctl_pkg::RAS_DEPTH), .W(AW)) u_ras (
        .clk(clk),
        .reset(reset),
        .push(fetch_valid && fetch_is_call),
        .push_addr(fetch_next_pc),
        .pop(fetch_valid && fetch_is_ret),
        .top_addr(ras_top),
        .empty(ras_empty)
    );

    // Misprediction detection
    logic mispredict, res_ok;
    assign mispredict = res_valid && (res_taken != res_pred_taken);
    assign res_ok = res_valid && !mispredict;

    // Fetch redirect
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            redirect_q <= 1'b0;
            redirect_pc_q <= '0;
            pred_taken_q <= 1'b0;
            alt_valid_q <= 1'b0;
            alt_pc_q <= '0;
        end
        else if (mispredict)
        begin
            redirect_q <= 1'b1;
            redirect_pc_q <= res_taken ? res_target : res_next_pc;
            pred_taken_q <= 1'b0;
            alt_valid_q <= 1'b0;
        end
        else if (fetch_valid && fetch_is_ret && !ras_empty)
        begin
            redirect_q <= 1'b1;
            redirect_pc_q <= ras_top;
            pred_taken_q <= 1'b1;
            alt_valid_q <= 1'b0;
        end
        else if (fetch_valid && fetch_is_branch && !fetch_is_cond)
        begin
            redirect_q <= |f_hit;
            redirect_pc_q <= f_tgt;
            pred_taken_q <= |f_hit;
            alt_valid_q <= 1'b0;
        end
        else if (fetch_valid && fetch_is_cond)
        begin
            // Miss stays sequential
            redirect_q <= (|f_hit) && f_taken;
            redirect_pc_q <= f_tgt;
            pred_taken_q <= (|f_hit) && f_taken;
            // Alternate path prefetch
            alt_valid_q <= |f_hit;
            alt_pc_q <= f_taken ? fetch_next_pc : f_tgt;
        end
        else
        begin
            redirect_q <= 1'b0;
            pred_taken_q <= 1'b0;
            alt_valid_q <= 1'b0;
        end
    end

    // Valid bits and victim
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < TGT_N; i++)
                bt_v_q[i] <= 1'b0;
            victim_q <= '0;
        end
        else if (res_valid && res_taken && !(|r_hit))
        begin
            bt_v_q[{set_of(res_pc), victim_q}] <= 1'b1;
            victim_q <= victim_q + 1'b1;
        end
    end

    // Tag and target update
    always_ff @(posedge clk)
    begin
        if (res_valid && res_taken)
        begin
            if (|r_hit)
                bt_pc_q[{set_of(res_pc), way_of(r_hit)}] <= res_target;
            else
            begin
                bt_tag_q[{set_of(res_pc), victim_q}] <= tag_of(res_pc);
                bt_pc_q[{set_of(res_pc), victim_q}] <= res_target;
            end
        end
    end

    // Saturating two-bit history counters
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < BHT_N; i++)
                bht_q[i] <= spec_ctl_pkg::CTR_RESET;
        end
        else if (res_valid)
        begin
            if (res_taken && bht_q[hidx(res_pc)] != spec_ctl_pkg::CTR_MAX)
                bht_q[hidx(res_pc)] <= bht_q[hidx(res_pc)] + 1'b1;
            else if (!res_taken
                && bht_q[hidx(res_pc)] != spec_ctl_pkg::CTR_MIN)
                bht_q[hidx(res_pc)] <= bht_q[hidx(res_pc)] - 1'b1;
        end
    end

    // Resolution and penalty
    logic [2:0] pen_q;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            res_late_q <= 1'b0;
            branch_done_q <= 1'b0;
            flush_q <= 1'b0;
            pen_q <= '0;
            fetch_hold_q <= 1'b0;
        end
        else
        begin
            if (res_valid)
                res_late_q <= res_cc_parallel;
            branch_done_q <= res_ok;
            flush_q <= mispredict;
            if (mispredict)
            begin
                pen_q <= (res_cc_parallel ? PEN_W : PEN_E) - 3'h1;
                fetch_hold_q <= 1'b1;
            end
            else if (pen_q != '0)
                pen_q <= pen_q - 3'h1;
            else
                fetch_hold_q <= 1'b0;
        end
    end

    // Primary pipe only
    always_ff @(posedge clk)
    begin
        if (reset)
            issue_x_only_q <= 1'b0;
        else
            issue_x_only_q <= dec_valid && dec_is_cond;
    end

    // Result forwarding
    logic fwd;
    assign fwd = x_res_valid && y_valid && y_is_move
        && y_src_lreg == x_res_lreg;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            y_move_data_valid_q <= 1'b0;
            y_move_data_q <= '0;
            y_move_to_mem_q <= 1'b0;
            fwd_used_q <= 1'b0;
        end
        else
        begin
            y_move_data_valid_q <= y_valid && y_is_move;
            y_move_data_q <= fwd ? x_res_data : y_reg_data;
            y_move_to_mem_q <= y_valid && y_is_move && y_dest_mem;
            fwd_used_q <= fwd;
        end
    end

    // Memory data bypass
    logic byp, same_addr;
    assign same_addr = x_mem_wr && y_mem_rd && x_mem_addr == y_mem_addr;
    assign byp = same_addr && y_cacheable;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            byp_used_q <= 1'b0;
            byp_data_q <= '0;
            y_mem_read_q <= 1'b0;
            y_stall_q <= 1'b0;
        end
        else
        begin
            byp_used_q <= byp;
            if (byp)
                byp_data_q <= x_mem_wdata;
            y_mem_read_q <= y_mem_rd && !byp;
            // One-clock stall
            y_stall_q <= byp && !y_stall_q;
        end
    end

    // Speculation level bookkeeping
    logic spec_op, halt, accept;
    logic [1:0] retire;
    logic [LW-1:0] head_q;
    assign spec_op = dec_valid && (dec_is_cond || dec_is_fpu);
    assign halt = (spec_op && spec_level_q == LVL_MAX) || fault
        || wbuf_full || noncp_write;
    assign accept = spec_op && !halt && !mispredict;
    assign retire = 2'(res_ok) + 2'(fpu_done);
    // Retiring never takes the level below zero
    logic [2:0] lvl_up, lvl_nx;
    assign lvl_up = spec_level_q + 3'(accept);
    assign lvl_nx = lvl_up > 3'(retire) ? lvl_up - 3'(retire) : 3'h0;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            spec_level_q <= '0;
            head_q <= '0;
        end
        else if (mispredict)
        begin
            spec_level_q <= '0;
            head_q <= '0;
        end
        else
        begin
            spec_level_q <= lvl_nx;
            head_q <= head_q + LW'(lvl_up - lvl_nx);
        end
    end

    // Checkpoint strobes and write gating
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            spec_halt_q <= 1'b0;
            spec_accept_q <= 1'b0;
            ckpt_save_q <= 1'b0;
            ckpt_restore_q <= 1'b0;
            ckpt_clear_q <= 1'b0;
            mem_commit_en_q <= 1'b1;
            spec_write_discard_q <= 1'b0;
        end
        else
        begin
            spec_halt_q <= halt;
            spec_accept_q <= accept;
            ckpt_save_q <= accept;
            ckpt_restore_q <= mispredict;
            ckpt_clear_q <= res_ok || fpu_done;
            // Commit only when not speculative
            mem_commit_en_q <= mispredict || lvl_nx == '0;
            spec_write_discard_q <= mispredict;
        end
    end

    // Register pool
    logic [NPHYS-1:0] free_q;
    logic [4:0] map_q [NL];
    logic [4:0] ckpt_q [spec_ctl_pkg::SPEC_MAX][NL];
    logic [4:0] pick;
    logic pick_ok;

    function automatic logic [5:0] first_free(input logic [NPHYS-1:0] f);
        first_free = '0;
        for (int i = NPHYS - 1; i >= 0; i--)
            if (f[i])
                first_free = {1'b1, 5'(i)};
    endfunction

    assign {pick_ok, pick} = first_free(free_q);

    // Free list
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            free_q <= {{(NPHYS-NL){1'b1}}, {NL{1'b0}}};
            alloc_ok_q <= 1'b0;
            alloc_phys_q <= '0;
        end
        else
        begin
            alloc_ok_q <= alloc_req && pick_ok;
            if (alloc_req && pick_ok)
            begin
                alloc_phys_q <= pick;
                free_q[pick] <= 1'b0;
            end
            if (free_req)
                free_q[free_phys] <= 1'b1;
        end
    end

    // Rename map and restore
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NL; i++)
                map_q[i] <= 5'(i);
        end
        else if (mispredict && spec_level_q != '0)
        begin
            for (int i = 0; i < NL; i++)
                map_q[i] <= ckpt_q[head_q][i];
        end
        else if (alloc_req && pick_ok)
            map_q[alloc_lreg] <= pick;
    end

    always_ff @(posedge clk)
    begin
        if (accept)
        begin
            for (int i = 0; i < NL; i++)
                ckpt_q[head_q + LW'(spec_level_q)][i] <= map_q[i];
        end
    end

    // Rename lookup
    always_ff @(posedge clk)
    begin
        if (reset)
            rd_phys_q <= '0;
        else
            rd_phys_q <= map_q[rd_lreg];
    end
endmodule // branch_speculation_forwarding
`default_nettype wire

// file: tb/bsf_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bsf_chk (
    // Clock and reset
    input wire logic clk, reset,
    // Forwarding and bypass
    input wire logic x_res_valid, y_valid, y_is_move, fwd_used_q,
    input wire logic x_mem_wr, y_mem_rd, y_cacheable,
    input wire logic byp_used_q, y_stall_q, y_mem_read_q,
    input wire logic [2:0] x_res_lreg, y_src_lreg,
    input wire logic [31:0] x_res_data, y_move_data_q, x_mem_addr,
    input wire logic [31:0] y_mem_addr, x_mem_wdata, byp_data_q,
    // Resolution and speculation
    input wire logic res_valid, res_taken, res_pred_taken, res_cc_parallel,
    input wire logic flush_q, fetch_hold_q, ckpt_restore_q,
    input wire logic dec_valid, dec_is_cond, dec_is_fpu,
    input wire logic spec_accept_q, spec_halt_q, mem_commit_en_q,
    input wire logic [2:0] spec_level_q
);
    // Clocking
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Paired pipes
    fwd_result_a: assert property (x_res_valid && y_valid && y_is_move
        && x_res_lreg == y_src_lreg |=> fwd_used_q
        && y_move_data_q == $past(x_res_data)) else $error("fwd data");
    byp_hit_a: assert property (x_mem_wr && y_mem_rd && y_cacheable
        && x_mem_addr == y_mem_addr |=> byp_used_q && y_stall_q
        && !y_mem_read_q && byp_data_q == $past(x_mem_wdata))
        else $error("bypass hit");
    byp_uncached_a: assert property (y_mem_rd && !y_cacheable
        |=> !byp_used_q && y_mem_read_q) else $error("bypass uncached");
    // Penalty
    pen_execute_a: assert property (res_valid && !res_cc_parallel
        && res_taken != res_pred_taken |=> flush_q ##0 fetch_hold_q [*4]
        ##1 !fetch_hold_q) else $error("penalty execute");
    pen_writeback_a: assert property (res_valid && res_cc_parallel
        && res_taken != res_pred_taken |=> flush_q ##0 fetch_hold_q [*5]
        ##1 !fetch_hold_q) else $error("penalty writeback");
    restore_state_a: assert property (res_valid
        && res_taken != res_pred_taken |=> ckpt_restore_q
        && spec_level_q == 3'h0) else $error("restore");
    // Speculation
    level_limit_a: assert property (dec_valid && spec_level_q == 3'h4
        && (dec_is_cond || dec_is_fpu) |=> !spec_accept_q && spec_halt_q)
        else $error("level limit");
    commit_hold_a: assert property (mem_commit_en_q
        == (spec_level_q == 3'h0)) else $error("commit hold");
endmodule // bsf_chk
bind branch_speculation_forwarding bsf_chk chk_i (.*);
`default_nettype wire

// file: tb/pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
    // Clock
    input wire logic clk,
    // Branch resolution towards the block
    output logic res_valid, res_taken, res_pred_taken, res_cc_parallel,
    output logic [31:0] res_pc, res_target, res_next_pc
);
    // Idle buses
    initial
    begin
        {res_valid, res_taken, res_pred_taken, res_cc_parallel} = 4'h0;
        {res_pc, res_target, res_next_pc} = '0;
    end
    // One-cycle resolution
    task automatic resolve(input logic [31:0] pc, tgt,
                           input logic tk, pt, par);
        @(negedge clk);
        {res_valid, res_taken, res_pred_taken} = {1'b1, tk, pt};
        res_cc_parallel = par;
        {res_pc, res_target, res_next_pc} = {pc, tgt, pc + 32'h4};
        @(negedge clk);
        res_valid = 1'b0;
        {res_pc, res_target, res_next_pc} = ~{res_pc, res_target, res_next_pc};
    endtask
endmodule // pipe_model
`default_nettype wire

// file: tb/branch_speculation_forwarding_tb.sv
`timescale 1ns/1ps
`default_nettype none
module branch_speculation_forwarding_tb;
    logic clk, reset;
    logic x_res_valid, y_valid, y_is_move, y_dest_mem, x_mem_wr, y_mem_rd;
    logic y_cacheable, fetch_valid, fetch_is_branch, fetch_is_cond;
    logic fetch_is_call, fetch_is_ret, dec_valid, dec_is_cond, dec_is_fpu;
    logic fpu_done, fault, wbuf_full, noncp_write, alloc_req, free_req;
    logic res_valid, res_taken, res_pred_taken, res_cc_parallel;
    logic [2:0] x_res_lreg, y_src_lreg, alloc_lreg, rd_lreg, spec_level_q;
    logic [4:0] free_phys, alloc_phys_q, rd_phys_q;
    logic [31:0] x_res_data, y_reg_data, x_mem_addr, x_mem_wdata, y_mem_addr;
    logic [31:0] fetch_pc, fetch_next_pc, res_pc, res_target, res_next_pc;
    logic y_move_data_valid_q, y_move_to_mem_q, fwd_used_q, byp_used_q;
    logic y_mem_read_q, y_stall_q, redirect_q, pred_taken_q, alt_valid_q;
    logic issue_x_only_q, spec_accept_q, res_late_q, branch_done_q, flush_q;
    logic fetch_hold_q, spec_halt_q, ckpt_save_q, ckpt_restore_q, ckpt_clear_q;
    logic mem_commit_en_q, spec_write_discard_q, alloc_ok_q;
    logic [31:0] y_move_data_q, byp_data_q, redirect_pc_q, alt_pc_q;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    branch_speculation_forwarding dut (.*);
    pipe_model pm (.*);

    // Clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (++cycles == 3000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run;
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Result forwarding
    task automatic t_fwd;
        @(negedge clk);
        {x_res_valid, y_valid, y_is_move, y_dest_mem} = 4'hf;
        {x_res_lreg, y_src_lreg} = 6'h12;
        {x_res_data, y_reg_data} = {32'h1234_5678, 32'h0bad_0bad};
        @(negedge clk);
        chk(y_move_data_q, 32'h1234_5678);
        chk({fwd_used_q, y_move_to_mem_q, y_move_data_valid_q}, 3'h7);
        y_src_lreg = 3'h5;
        @(negedge clk);
        chk({fwd_used_q, y_move_data_q}, {1'b0, 32'h0bad_0bad});
        {y_is_move, y_src_lreg} = 4'h2;
        @(negedge clk);
        {x_res_valid, y_valid, y_dest_mem} = 3'h0;
        chk({fwd_used_q, y_move_data_valid_q}, 2'h0);
    endtask

    // Memory data bypass
    task automatic t_byp;
        @(negedge clk);
        {x_mem_wr, y_mem_rd, y_cacheable} = 3'h7;
        {x_mem_addr, y_mem_addr, x_mem_wdata} = {32'h40, 32'h40, 32'hcafe_f00d};
        @(negedge clk);
        y_cacheable = 1'b0;
        chk({byp_used_q, y_stall_q, y_mem_read_q}, 3'h6);
        chk(byp_data_q, 32'hcafe_f00d);
        @(negedge clk);
        {x_mem_wr, y_mem_rd} = 2'h0;
        chk({byp_used_q, y_mem_read_q, y_stall_q}, 3'h2);
    endtask

    task automatic fetch(input logic [3:0] kind, input logic [31:0] pc);
        @(negedge clk);
        {fetch_valid, fetch_is_branch, fetch_is_cond} = {1'b1, kind[3:2]};
        {fetch_is_call, fetch_is_ret} = kind[1:0];
        {fetch_pc, fetch_next_pc} = {pc, pc + 32'h4};
        @(negedge clk);
        {fetch_valid, fetch_is_branch, fetch_is_cond} = 3'h0;
        {fetch_is_call, fetch_is_ret} = 2'h0;
    endtask

    // Mispredict and hold window
    task automatic mis(input logic par, tk);
        int n;
        pm.resolve(32'h100, 32'h800, tk, !tk, par);
        chk({flush_q, redirect_q, ckpt_restore_q}, 3'h7);
        chk(redirect_pc_q, tk ? 32'h800 : 32'h104);
        chk({res_late_q, spec_write_discard_q}, {par, 1'b1});
        chk({spec_level_q, mem_commit_en_q}, 4'h1);
        n = 0;
        while (fetch_hold_q === 1'b1 && n < 9)
        begin
            n++;
            @(negedge clk);
        end
        chk(n, par ? spec_ctl_pkg::PEN_WRITEBACK : spec_ctl_pkg::PEN_EXECUTE);
    endtask

    // Prediction paths
    task automatic t_branch;
        mis(1'b0, 1'b1);
        fetch(4'h4, 32'h100);
        chk({redirect_q, pred_taken_q, alt_valid_q}, 3'h7);
        chk({redirect_pc_q, alt_pc_q}, {32'h800, 32'h104});
        fetch(4'h8, 32'h100);
        chk({redirect_q, redirect_pc_q}, {1'b1, 32'h800});
        fetch(4'h4, 32'h200);
        chk({redirect_q, alt_valid_q}, 2'h0);
        pm.resolve(32'h100, 32'h800, 1'b0, 1'b0, 1'b0);
        chk({branch_done_q, fetch_hold_q, flush_q}, 3'h4);
        fetch(4'h4, 32'h100);
        chk({redirect_q, alt_valid_q, alt_pc_q}, {2'h1, 32'h800});
        mis(1'b1, 1'b0);
    endtask

    // Return stack
    task automatic t_ras;
        fetch(4'h2, 32'h300);
        fetch(4'h1, 32'h500);
        chk({redirect_q, redirect_pc_q}, {1'b1, 32'h304});
    endtask

    task automatic dec(input logic c, f);
        @(negedge clk);
        {dec_valid, dec_is_cond, dec_is_fpu} = {1'b1, c, f};
        @(negedge clk);
        {dec_valid, dec_is_cond, dec_is_fpu} = 3'h0;
    endtask

    // Speculation levels
    task automatic t_spec;
        for (int i = 1; i <= 4; i++)
        begin
            dec(i[0], !i[0]);
            chk({spec_accept_q, ckpt_save_q, spec_level_q}, {2'h3, i[2:0]});
            chk({issue_x_only_q, mem_commit_en_q}, {i[0], 1'b0});
        end
        dec(1'b1, 1'b0);
        chk({spec_accept_q, spec_halt_q, spec_level_q}, 5'h0c);
        @(negedge clk);
        fpu_done = 1'b1;
        @(negedge clk);
        fpu_done = 1'b0;
        chk(spec_level_q, 3'h3);
        pm.resolve(32'h600, 32'h900, 1'b1, 1'b1, 1'b0);
        chk({branch_done_q, ckpt_clear_q, spec_level_q}, 5'h1a);
        mis(1'b0, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            {fault, wbuf_full, noncp_write} = 3'h4 >> i;
            dec(1'b1, 1'b0);
            chk({spec_accept_q, spec_halt_q}, 2'h1);
        end
        {fault, wbuf_full, noncp_write} = 3'h0;
    endtask

    // Register pool
    task automatic t_pool;
        for (int i = 0; i < 2; i++)
        begin
            @(negedge clk);
            {alloc_req, alloc_lreg, rd_lreg} = 7'h5b;
            @(negedge clk);
            alloc_req = 1'b0;
            chk({alloc_ok_q, alloc_phys_q}, 6'h28 + i);
        end
        @(negedge clk);
        chk(rd_phys_q, 5'h09);
    endtask

    // Reset and scenarios
    initial
    begin
        {x_res_valid, y_valid, y_is_move, y_dest_mem, x_mem_wr, y_mem_rd} = '0;
        {y_cacheable, fetch_valid, fetch_is_branch, fetch_is_cond} = '0;
        {fetch_is_call, fetch_is_ret, dec_valid, dec_is_cond, dec_is_fpu} = '0;
        {fpu_done, fault, wbuf_full, noncp_write, alloc_req, free_req} = '0;
        reset = 1'b1;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        chk({mem_commit_en_q, spec_level_q}, 4'h8);
        t_fwd();
        t_byp();
        t_branch();
        t_ras();
        t_spec();
        t_pool();
        complete_run();
    end
endmodule // branch_speculation_forwarding_tb
`default_nettype wire
